// ---- smb_pkg.sv ----
// shared constants and types for the two-wire transfer controller
// assumes a cpu-side clock and a faster, unrelated link clock
package smb_pkg;

  // scl half period, in its own unit, and the link clock period
  localparam int T_HALF_NS      = 5000;
  localparam int LINK_PERIOD_NS = 12;
  localparam int HALF_CYC       = (T_HALF_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  localparam int TMR_W          = 12;

  localparam int SYNC_STAGES    = 3;

  // bit positions within a nine-bit frame
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [3:0] BIT_LAST  = 4'h7;
  localparam logic [3:0] BIT_ACK   = 4'h8;

  // sub-steps of the link sequencer
  localparam logic [1:0] STEP_0 = 2'h0;
  localparam logic [1:0] STEP_1 = 2'h1;
  localparam logic [1:0] STEP_2 = 2'h2;
  localparam logic [1:0] STEP_3 = 2'h3;

  // widths of the crossed vectors
  localparam int CFG_W  = 17;
  localparam int STAT_W = 15;

  typedef enum logic [2:0] {
    SMB_IDLE,
    SMB_START,
    SMB_BIT,
    SMB_HOLD,
    SMB_STOP,
    SMB_IGNORE
  } smb_link_e;

endpackage

// ---- smb_pulse_xfer.sv ----
// one-cycle event from one clock domain to another by a toggle
// assumes events are spaced by several destination cycles
`timescale 1ns/1ps
`default_nettype none
module smb_pulse_xfer (
  input  wire logic src_clk_i,
  input  wire logic dst_clk_i,
  input  wire logic rst_n_i,
  input  wire logic pulse_i,
  output var  logic pulse_o
);

  logic tog_ff;
  logic tog_dst;
  logic seen_ff;

  always_ff @(posedge src_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tog_ff <= 1'b0;
    end else if (pulse_i) begin
      tog_ff <= ~tog_ff;
    end
  end

  smb_sync #(.WIDTH(1), .STAGES(smb_pkg::SYNC_STAGES)) u_sync (
    .clk_i   (dst_clk_i),
    .rst_n_i (rst_n_i),
    .d_i     (tog_ff),
    .q_o     (tog_dst)
  );

  always_ff @(posedge dst_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      seen_ff <= 1'b0;
      pulse_o <= 1'b0;
    end else begin
      seen_ff <= tog_dst;
      pulse_o <= tog_dst ^ seen_ff;
    end
  end

endmodule
`default_nettype wire

// ---- smb_remote.sv ----
// remote target model: acks its address, keeps written bytes, serves a read byte
// assumes pulled-up lines resolved by the bench; it only pulls sda low
`timescale 1ns/1ps
`default_nettype none
module smb_remote #(
  parameter logic [6:0] ADDR    = 7'h5A,
  parameter logic [7:0] RD_BYTE = 8'hC3
) (
  input  wire logic scl_i,
  input  wire logic sda_i,
  output var  logic pull_o
);
  int cnt = 0, stops = 0;
  logic adr = 0, rd = 0, sel = 0, mack = 0;
  logic [7:0] sh = 8'h00, got = 8'h00;
  initial pull_o = 0;
  always @(negedge sda_i) if (scl_i) begin
    cnt = 0;
    adr = 1;
    sel = 0;
  end
  always @(posedge sda_i) if (scl_i && sel) begin
    stops++;
    sel = 0;
  end
  always @(posedge scl_i) begin
    if (cnt < 8) sh = {sh[6:0], sda_i};
    else if (rd && !adr) mack = !sda_i;
    cnt++;
  end
  always @(negedge scl_i) begin
    if (cnt == 9) begin
      cnt = 0;
      adr = 0;
    end
    if (cnt == 8 && adr) begin
      rd = sh[0];
      sel = (sh[7:1] == ADDR);
    end
    if (cnt == 8 && !adr && !rd && sel) got = sh;
    pull_o = sel && (cnt == 8 ? (adr || !rd) : (rd && !adr && !RD_BYTE[7-cnt]));
  end
endmodule
`default_nettype wire

// ---- smb_sync.sv ----
// level synchroniser: a chain of flops, output moves when the last two agree
// assumes the input is a level that holds for several destination cycles
`timescale 1ns/1ps
`default_nettype none
module smb_sync #(
  parameter int WIDTH  = 1,
  parameter int STAGES = smb_pkg::SYNC_STAGES
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] d_i,
  output var  logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] chain_ff [STAGES];

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < STAGES; i++) begin
        chain_ff[i] <= '0;
      end
    end else begin
      chain_ff[0] <= d_i;
      for (int i = 1; i < STAGES; i++) begin
        chain_ff[i] <= chain_ff[i-1];
      end
    end
  end

  // per bit: take the new value only once the two last stages agree
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_o <= '0;
    end else begin
      q_o <= (chain_ff[STAGES-1] & ~(chain_ff[STAGES-1] ^ chain_ff[STAGES-2]))
           | (q_o & (chain_ff[STAGES-1] ^ chain_ff[STAGES-2]));
    end
  end

endmodule
`default_nettype wire

// ---- smb_xfer_ctrl.sv ----
// two-wire bus transfer controller: master/slave, transmit/receive
// assumes open-drain pins resolved outside; link clock unrelated to clk_i
//
// Behaviour
// - always exactly one of master/slave and transmit/receive modes
// - master from generated start until arbitration loss or generated stop
// - interrupt at the end of every byte frame in every mode, except a refused slave address
// - receiving: interrupt before ack if auto-ack off, after it if on
// - transmitting: interrupt always after the ack bit
// - master write: start, address with direction 0, then acked data
// - master read: address with direction 1, then clock in slave data
// - stop request in master transmitter generates a stop ending transfer
// - master receiver ends after stop request and generated stop
// - master transmitter with no data write becomes master receiver
// - data write as master receiver switches to master transmitter
// - auto-ack off: flag ack request, interrupt; software picks ack
// - auto-ack on: drive ack or nack itself, then interrupt
// - ack bit 1 sends ack, ack bit 0 sends nack
// - inhibit low: start plus address enters slave receiver, both directions
// - auto-ack off: address raises interrupt and ack request for software
// - auto-ack on: ack address only on masked match, interrupt after ack
// - refused address suppresses slave interrupts until next start
// - stop leaves slave receiver; data write switches to slave transmitter
// - slave transmitter: data write after master nack flags an error
// - stop leaves slave transmitter; no data write reverts to receiver
`timescale 1ns/1ps
`default_nettype none
module smb_xfer_ctrl #(
  parameter int HALF_CYC = smb_pkg::HALF_CYC
) (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       link_clk_i,
  input  wire logic       start_request_i,
  input  wire logic       stop_request_bit_i,
  input  wire logic       ack_bit_i,
  input  wire logic       auto_ack_en_i,
  input  wire logic       slave_event_inhibit_i,
  input  wire logic [6:0] own_slave_address_register_i,
  input  wire logic [6:0] slave_address_mask_register_i,
  input  wire logic       serial_byte_register_wr_i,
  input  wire logic [7:0] serial_byte_register_i,
  input  wire logic       irq_clear_i,
  output var  logic       irq_flag_o,
  output logic [7:0]      serial_byte_register_o,
  output logic            master_o,
  output logic            tx_mode_o,
  output logic            ack_request_flag_o,
  output logic            ack_received_o,
  output logic            arb_lost_o,
  output logic            error_o,
  output logic            busy_o,
  input  wire logic       scl_i,
  output var  logic       scl_o,
  output var  logic       scl_oe_o,
  input  wire logic       sda_i,
  output var  logic       sda_o,
  output var  logic       sda_oe_o
);

  localparam logic [smb_pkg::TMR_W-1:0] HALF = smb_pkg::TMR_W'(HALF_CYC);

  // ---------------- cpu domain ----------------
  logic       evt_c;
  logic       go_ff;
  logic       sta_ff;
  logic       sto_ff;
  logic       wrote_ff;
  logic [7:0] byte_ff;
  logic       cmd_sta_ff;
  logic       cmd_sto_ff;
  logic       cmd_ack_ff;
  logic       cmd_wrote_ff;
  logic [7:0] cmd_byte_ff;
  logic       nxt_go;

  // releasing a held frame, or a start request while the link is idle
  assign nxt_go = (irq_flag_o & irq_clear_i & ~evt_c)
                | (~irq_flag_o & ~busy_o & start_request_i & ~go_ff);

  // event set wins over a same-cycle software clear
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_flag_o <= 1'b0;
    end else if (evt_c) begin
      irq_flag_o <= 1'b1;
    end else if (irq_clear_i) begin
      irq_flag_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      go_ff    <= 1'b0;
      sta_ff   <= 1'b0;
      sto_ff   <= 1'b0;
      wrote_ff <= 1'b0;
      byte_ff  <= 8'h00;
    end else begin
      go_ff <= nxt_go;
      if (serial_byte_register_wr_i) begin
        byte_ff <= serial_byte_register_i;
      end
      sta_ff   <= nxt_go ? 1'b0 : (sta_ff | start_request_i);
      sto_ff   <= nxt_go ? 1'b0 : (sto_ff | stop_request_bit_i);
      wrote_ff <= nxt_go ? 1'b0 : (wrote_ff | serial_byte_register_wr_i);
    end
  end

  // command snapshot, stable from the release until the next release
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd_sta_ff   <= 1'b0;
      cmd_sto_ff   <= 1'b0;
      cmd_ack_ff   <= 1'b0;
      cmd_wrote_ff <= 1'b0;
      cmd_byte_ff  <= 8'h00;
    end else if (nxt_go) begin
      cmd_sta_ff   <= sta_ff | start_request_i;
      cmd_sto_ff   <= sto_ff | stop_request_bit_i;
      cmd_ack_ff   <= ack_bit_i;
      cmd_wrote_ff <= wrote_ff | serial_byte_register_wr_i;
      cmd_byte_ff  <= serial_byte_register_wr_i ? serial_byte_register_i : byte_ff;
    end
  end

  // ---------------- link domain ----------------
  logic                     go_l;
  logic                     scl_s;
  logic                     sda_s;
  logic [smb_pkg::CFG_W-1:0] cfg_l;
  smb_pkg::smb_link_e       st_ff;
  logic                     scl_prev_ff;
  logic                     sda_prev_ff;
  logic                     master_ff;
  logic                     tx_ff;
  logic                     addr_ph_ff;
  logic [3:0]               bit_ff;
  logic [1:0]               step_ff;
  logic [7:0]               sh_ff;
  logic [7:0]               rx_ff;
  logic [smb_pkg::TMR_W-1:0] tmr_ff;
  logic                     ack_request_flag_ff;
  logic                     rack_ff;
  logic                     acked_ff;
  logic                     arb_ff;
  logic                     err_ff;
  logic                     pre_ack_ff;
  logic                     skip_post_ff;
  logic                     pend_sta_ff;
  logic                     pend_sto_ff;
  logic                     evt_ff;

  // pins cross inverted so that the reset value reads as an idle high line
  logic scl_low_s;
  logic sda_low_s;

  smb_sync #(.WIDTH(2), .STAGES(smb_pkg::SYNC_STAGES)) u_pin_sync (
    .clk_i   (link_clk_i),
    .rst_n_i (rst_n_i),
    .d_i     ({~scl_i, ~sda_i}),
    .q_o     ({scl_low_s, sda_low_s})
  );

  assign scl_s = ~scl_low_s;
  assign sda_s = ~sda_low_s;

  // configuration levels, expected to change only while the bus is quiet
  smb_sync #(.WIDTH(smb_pkg::CFG_W), .STAGES(smb_pkg::SYNC_STAGES)) u_cfg_sync (
    .clk_i   (link_clk_i),
    .rst_n_i (rst_n_i),
    .d_i     ({slave_event_inhibit_i, auto_ack_en_i, ack_bit_i,
                own_slave_address_register_i, slave_address_mask_register_i}),
    .q_o     (cfg_l)
  );

  smb_pulse_xfer u_go_xfer (
    .src_clk_i (clk_i),
    .dst_clk_i (link_clk_i),
    .rst_n_i   (rst_n_i),
    .pulse_i   (go_ff),
    .pulse_o   (go_l)
  );

  smb_pulse_xfer u_evt_xfer (
    .src_clk_i (link_clk_i),
    .dst_clk_i (clk_i),
    .rst_n_i   (rst_n_i),
    .pulse_i   (evt_ff),
    .pulse_o   (evt_c)
  );

  logic inhibit_l;
  logic auto_ack_l;
  logic ack_cfg_l;
  logic addr_match;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic tmr_done;
  logic sample_now;
  logic advance_now;
  logic ack_val;

  assign inhibit_l  = cfg_l[16];
  assign auto_ack_l = cfg_l[15];
  assign ack_cfg_l  = cfg_l[14];
  // compare only the address bits selected by the mask
  assign addr_match = (((sh_ff[7:1] ^ cfg_l[13:7]) & cfg_l[6:0]) == 7'h00);
  assign scl_rise   = scl_s & ~scl_prev_ff;
  assign scl_fall   = ~scl_s & scl_prev_ff;
  assign start_det  = scl_s & scl_prev_ff & sda_prev_ff & ~sda_s;
  assign stop_det   = scl_s & scl_prev_ff & ~sda_prev_ff & sda_s;
  assign tmr_done   = (tmr_ff == '0);
  assign sample_now = (st_ff == smb_pkg::SMB_BIT) & (master_ff
                    ? (step_ff == smb_pkg::STEP_1 & scl_s)
                    : (step_ff == smb_pkg::STEP_0 & scl_rise));
  assign advance_now = (st_ff == smb_pkg::SMB_BIT) & (master_ff
                     ? (step_ff == smb_pkg::STEP_2 & tmr_done)
                     : (step_ff == smb_pkg::STEP_1 & scl_fall));
  // slave address phase acks on match, data bytes use the preset ack bit
  assign ack_val = (addr_ph_ff & ~master_ff) ? addr_match : ack_cfg_l;

  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end else begin
      scl_prev_ff <= scl_s;
      sda_prev_ff <= sda_s;
    end
  end

  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= smb_pkg::SMB_IDLE;
      {master_ff, tx_ff, addr_ph_ff, ack_request_flag_ff, rack_ff, acked_ff} <= 6'h00;
      {arb_ff, err_ff, pre_ack_ff, skip_post_ff, pend_sta_ff, pend_sto_ff} <= 6'h00;
      {evt_ff, scl_oe_o, sda_oe_o} <= 3'h0;
      bit_ff  <= smb_pkg::BIT_FIRST;
      step_ff <= smb_pkg::STEP_0;
      sh_ff   <= 8'h00;
      rx_ff   <= 8'h00;
      tmr_ff  <= '0;
    end else begin
      evt_ff <= 1'b0;
      if (!tmr_done) begin
        tmr_ff <= tmr_ff - 1'b1;
      end
      if (sample_now) begin
        if (bit_ff == smb_pkg::BIT_ACK) begin
          if (tx_ff) begin
            rack_ff <= ~sda_s;
          end
        end else begin
          sh_ff <= {sh_ff[6:0], sda_s};
        end
        if (master_ff) begin
          tmr_ff  <= HALF;
          step_ff <= smb_pkg::STEP_2;
        end else begin
          step_ff <= smb_pkg::STEP_1;
        end
      end
      unique case (st_ff)
        smb_pkg::SMB_IDLE: begin
          if (go_l && cmd_sta_ff) begin
            pend_sta_ff <= 1'b1;
          end
          if ((pend_sta_ff || (go_l && cmd_sta_ff)) && scl_s && sda_s && !start_det) begin
            st_ff   <= smb_pkg::SMB_START;
            step_ff <= smb_pkg::STEP_0;
          end else if (start_det && !inhibit_l) begin
            st_ff      <= smb_pkg::SMB_BIT;
            master_ff  <= 1'b0;
            tx_ff      <= 1'b0;
            addr_ph_ff <= 1'b1;
            bit_ff     <= smb_pkg::BIT_FIRST;
            step_ff    <= smb_pkg::STEP_2;
          end
        end
        smb_pkg::SMB_START: begin
          unique case (step_ff)
            smb_pkg::STEP_0: begin
              sda_oe_o <= 1'b0;
              scl_oe_o <= 1'b0;
              if (scl_s && sda_s) begin
                tmr_ff  <= HALF;
                step_ff <= smb_pkg::STEP_1;
              end
            end
            smb_pkg::STEP_1: begin
              if (tmr_done) begin
                sda_oe_o <= 1'b1;
                tmr_ff   <= HALF;
                step_ff  <= smb_pkg::STEP_2;
              end
            end
            default: begin
              if (tmr_done) begin
                scl_oe_o    <= 1'b1;
                master_ff   <= 1'b1;
                tx_ff       <= 1'b1;
                addr_ph_ff  <= 1'b1;
                arb_ff      <= 1'b0;
                err_ff      <= 1'b0;
                pend_sta_ff <= 1'b0;
                pre_ack_ff  <= 1'b0;
                evt_ff      <= 1'b1;
                st_ff       <= smb_pkg::SMB_HOLD;
              end
            end
          endcase
        end
        smb_pkg::SMB_BIT: begin
          if (!master_ff && (stop_det || start_det)) begin
            sda_oe_o <= 1'b0;
            scl_oe_o <= 1'b0;
            tx_ff    <= 1'b0;
            st_ff    <= (start_det && !inhibit_l) ? smb_pkg::SMB_BIT : smb_pkg::SMB_IDLE;
            addr_ph_ff <= 1'b1;
            bit_ff   <= smb_pkg::BIT_FIRST;
            step_ff  <= smb_pkg::STEP_2;
          end else if (master_ff && sample_now && tx_ff && bit_ff != smb_pkg::BIT_ACK
                       && !sda_oe_o && !sda_s) begin
            master_ff <= 1'b0;
            scl_oe_o  <= 1'b0;
            arb_ff    <= 1'b1;
            evt_ff    <= 1'b1;
            st_ff     <= smb_pkg::SMB_IDLE;
          end else if (master_ff && step_ff == smb_pkg::STEP_0 && tmr_done) begin
            scl_oe_o <= 1'b0;
            step_ff  <= smb_pkg::STEP_1;
          end else if (!master_ff && step_ff == smb_pkg::STEP_2 && scl_fall) begin
            step_ff <= smb_pkg::STEP_0;
          end else if (!master_ff && step_ff == smb_pkg::STEP_3) begin
            scl_oe_o <= 1'b0;
            step_ff  <= smb_pkg::STEP_0;
          end else if (advance_now) begin
            scl_oe_o <= master_ff;
            tmr_ff   <= HALF;
            step_ff  <= smb_pkg::STEP_0;
            if (bit_ff < smb_pkg::BIT_LAST) begin
              bit_ff   <= bit_ff + 1'b1;
              sda_oe_o <= tx_ff & ~sh_ff[7];
            end else if (bit_ff == smb_pkg::BIT_LAST) begin
              bit_ff <= smb_pkg::BIT_ACK;
              rx_ff  <= sh_ff;
              if (tx_ff) begin
                sda_oe_o <= 1'b0;
              end else if (!auto_ack_l) begin
                sda_oe_o   <= 1'b0;
                ack_request_flag_ff   <= 1'b1;
                pre_ack_ff <= 1'b1;
                scl_oe_o   <= 1'b1;
                evt_ff     <= 1'b1;
                st_ff      <= smb_pkg::SMB_HOLD;
              end else begin
                sda_oe_o <= ack_val;
                acked_ff <= ack_val;
              end
            end else begin
              sda_oe_o <= 1'b0;
              ack_request_flag_ff <= 1'b0;
              if (!master_ff && addr_ph_ff && !tx_ff && !acked_ff) begin
                scl_oe_o <= 1'b0;
                st_ff    <= smb_pkg::SMB_IGNORE;
              end else if (master_ff && skip_post_ff && pend_sto_ff) begin
                st_ff   <= smb_pkg::SMB_STOP;
                step_ff <= smb_pkg::STEP_0;
              end else if (skip_post_ff) begin
                skip_post_ff <= 1'b0;
                addr_ph_ff   <= 1'b0;
                bit_ff       <= smb_pkg::BIT_FIRST;
                sda_oe_o     <= tx_ff & ~sh_ff[7];
              end else begin
                if (!master_ff && addr_ph_ff) begin
                  tx_ff <= 1'b0;
                end
                addr_ph_ff <= 1'b0;
                pre_ack_ff <= 1'b0;
                scl_oe_o   <= 1'b1;
                evt_ff     <= 1'b1;
                st_ff      <= smb_pkg::SMB_HOLD;
              end
            end
          end
        end
        smb_pkg::SMB_HOLD: begin
          scl_oe_o <= 1'b1;
          if (!master_ff && (stop_det || start_det)) begin
            scl_oe_o <= 1'b0;
            sda_oe_o <= 1'b0;
            tx_ff    <= 1'b0;
            ack_request_flag_ff <= 1'b0;
            st_ff    <= smb_pkg::SMB_IDLE;
          end else if (go_l) begin
            st_ff   <= smb_pkg::SMB_BIT;
            step_ff <= master_ff ? smb_pkg::STEP_0 : smb_pkg::STEP_3;
            tmr_ff  <= HALF;
            if (pre_ack_ff) begin
              sda_oe_o     <= cmd_ack_ff;
              acked_ff     <= cmd_ack_ff;
              pre_ack_ff   <= 1'b0;
              skip_post_ff <= 1'b1;
              pend_sto_ff  <= cmd_sto_ff & master_ff;
              pend_sta_ff  <= cmd_sta_ff & master_ff;
              tx_ff        <= cmd_wrote_ff;
              if (cmd_wrote_ff) begin
                sh_ff <= cmd_byte_ff;
              end
            end else if (master_ff && cmd_sto_ff) begin
              st_ff       <= smb_pkg::SMB_STOP;
              step_ff     <= smb_pkg::STEP_0;
              pend_sta_ff <= cmd_sta_ff;
            end else if (master_ff && cmd_sta_ff) begin
              st_ff   <= smb_pkg::SMB_START;
              step_ff <= smb_pkg::STEP_0;
            end else begin
              bit_ff <= smb_pkg::BIT_FIRST;
              if (!master_ff && tx_ff && !rack_ff && cmd_wrote_ff) begin
                err_ff   <= 1'b1;
                tx_ff    <= 1'b0;
                sda_oe_o <= 1'b0;
              end else begin
                tx_ff    <= cmd_wrote_ff;
                sh_ff    <= cmd_wrote_ff ? cmd_byte_ff : 8'h00;
                sda_oe_o <= cmd_wrote_ff & ~cmd_byte_ff[7];
              end
            end
          end
        end
        smb_pkg::SMB_STOP: begin
          unique case (step_ff)
            smb_pkg::STEP_0: begin
              sda_oe_o <= 1'b1;
              tmr_ff   <= HALF;
              step_ff  <= smb_pkg::STEP_1;
            end
            smb_pkg::STEP_1: begin
              if (tmr_done) begin
                scl_oe_o <= 1'b0;
                step_ff  <= smb_pkg::STEP_2;
              end
            end
            smb_pkg::STEP_2: begin
              if (scl_s) begin
                tmr_ff  <= HALF;
                step_ff <= smb_pkg::STEP_3;
              end
            end
            default: begin
              if (tmr_done) begin
                sda_oe_o     <= 1'b0;
                master_ff    <= 1'b0;
                tx_ff        <= 1'b0;
                pend_sto_ff  <= 1'b0;
                skip_post_ff <= 1'b0;
                st_ff        <= smb_pkg::SMB_IDLE;
              end
            end
          endcase
        end
        default: begin
          if (start_det && !inhibit_l) begin
            st_ff      <= smb_pkg::SMB_BIT;
            addr_ph_ff <= 1'b1;
            tx_ff      <= 1'b0;
            bit_ff     <= smb_pkg::BIT_FIRST;
            step_ff    <= smb_pkg::STEP_2;
          end else if (stop_det || start_det) begin
            st_ff <= smb_pkg::SMB_IDLE;
          end
        end
      endcase
    end
  end

  // pins are open drain: the output level is always low
  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end
  end

  // status is stable while a frame is held, so a level crossing suffices
  smb_sync #(.WIDTH(smb_pkg::STAT_W), .STAGES(smb_pkg::SYNC_STAGES)) u_stat_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .d_i     ({master_ff, tx_ff, ack_request_flag_ff, rack_ff, arb_ff, err_ff,
                (st_ff != smb_pkg::SMB_IDLE) | master_ff, rx_ff}),
    .q_o     ({master_o, tx_mode_o, ack_request_flag_o, ack_received_o, arb_lost_o,
                error_o, busy_o, serial_byte_register_o})
  );

endmodule
`default_nettype wire

// ---- smb_xfer_ctrl_asserts.sv ----
// checker on the transfer controller ports
// bound into every smb_xfer_ctrl instance
`timescale 1ns/1ps
`default_nettype none
module smb_xfer_ctrl_asserts (
  input wire logic clk_i, rst_n_i, irq_flag_o, irq_clear_i, auto_ack_en_i, master_o,
  input wire logic tx_mode_o, ack_request_flag_o, arb_lost_o, error_o, busy_o,
  input wire logic scl_o, sda_o, scl_oe_o
);
  wire logic rq = irq_flag_o && ack_request_flag_o;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  chk_pins_low: assert property (!scl_o && !sda_o)
    else $error("pin level not low");
  chk_irq_stands: assert property (irq_flag_o && !irq_clear_i |=> irq_flag_o)
    else $error("irq lost");
  chk_irq_fall: assert property ($fell(irq_flag_o) |-> $past(irq_clear_i))
    else $error("irq fell alone");
  chk_ack_request_flag_rx: assert property (rq |-> !tx_mode_o)
    else $error("ack request in tx");
  chk_ack_request_flag_manual: assert property (rq |-> !auto_ack_en_i)
    else $error("ack request with auto ack");
  chk_arb_master: assert property (irq_flag_o && arb_lost_o |-> !master_o)
    else $error("master after arb loss");
  chk_err_slave_tx: assert property ($rose(error_o) |-> !master_o)
    else $error("error flagged while master");
  chk_frame_held: assert property (irq_flag_o && busy_o && !arb_lost_o |-> scl_oe_o)
    else $error("frame not held");
  cover property ($rose(irq_flag_o) && master_o && tx_mode_o);
  cover property (rq);
  cover property ($fell(busy_o));
endmodule
bind smb_xfer_ctrl smb_xfer_ctrl_asserts smb_xfer_ctrl_asserts_i (.*);
`default_nettype wire

// ---- smb_xfer_ctrl_bench.sv ----
// bench: master write and master reads against the remote target model
// assumes pulled-up lines; the link clock runs free, unrelated to clk_i
`timescale 1ns/1ps
`default_nettype none
module smb_xfer_ctrl_bench;
  localparam logic [6:0] ADR = 7'h5A;
  logic clk_i = 0, link_clk_i = 0, rst_n_i = 0, start_request_i = 0, stop_request_bit_i = 0;
  logic ack_bit_i = 0, auto_ack_en_i = 0, serial_byte_register_wr_i = 0, irq_clear_i = 0;
  logic slave_event_inhibit_i = 1;
  logic [6:0] own_slave_address_register_i = 7'h11, slave_address_mask_register_i = 7'h7F;
  logic [7:0] serial_byte_register_i = 8'h00, serial_byte_register_o;
  logic irq_flag_o, master_o, tx_mode_o, ack_request_flag_o, ack_received_o, arb_lost_o;
  logic error_o, busy_o, scl_o, scl_oe_o, sda_o, sda_oe_o, pull_o;
  wire logic scl_i = !scl_oe_o;
  // data lags the clock line slightly, as a receiver's hold time would have it
  wire logic sda_i;
  assign #1 sda_i = !(sda_oe_o || pull_o);
  wire logic [7:0] st = {4'h0, master_o, tx_mode_o, ack_request_flag_o, ack_received_o};
  int error_cnt = 0, check_count = 0;
  smb_xfer_ctrl #(.HALF_CYC(8)) smb_xfer_ctrl_i (.*);
  smb_remote #(.ADDR(ADR), .RD_BYTE(8'hC3)) smb_remote_i (.*);
  initial forever #12.5 clk_i = !clk_i;
  initial begin
    #3;
    forever #6 link_clk_i = !link_clk_i;
  end
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk_i);
    #2;
  endtask
  task automatic summarize();
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // irq high, or bus idle
  task automatic wait_for(input logic irq);
    int n;
    n = 0;
    while ((irq ? irq_flag_o !== 1 : busy_o !== 0) && n < 3000) begin
      tick();
      n++;
    end
    if (n == 3000) begin
      error_cnt++;
      summarize();
    end
  endtask
  // one release: optional byte, stop and start, then clear of a standing irq
  task automatic go(input logic wr, input logic [7:0] d, input logic stp, input logic sta);
    serial_byte_register_wr_i = wr;
    serial_byte_register_i = d;
    stop_request_bit_i = stp;
    start_request_i = sta;
    tick();
    serial_byte_register_wr_i = 0;
    stop_request_bit_i = 0;
    start_request_i = 0;
    irq_clear_i = irq_flag_o;
    tick();
    irq_clear_i = 0;
    tick(8);
    wait_for(!stp);
  endtask
  initial begin
    tick(4);
    rst_n_i = 1;
    tick(4);
    go(0, 8'h00, 0, 1);
    chk("start", 8'h0C, st & 8'hFE);
    go(1, {ADR, 1'b0}, 0, 0);
    chk("addr_w", 8'h0D, st);
    go(1, 8'hA5, 0, 0);
    chk("data_w", 8'hA5, smb_remote_i.got);
    chk("ack_w", 8'h0D, st);
    go(0, 8'h00, 1, 0);
    chk("stop_w", 8'h01, smb_remote_i.stops[7:0]);
    for (int aa = 0; aa < 2; aa++) begin
      auto_ack_en_i = aa[0];
      ack_bit_i = aa[0];
      go(0, 8'h00, 0, 1);
      go(1, {ADR, 1'b1}, 0, 0);
      chk("addr_r", 8'h0D, st);
      go(0, 8'h00, 0, 0);
      chk("rx_mode", aa[0] ? 8'h08 : 8'h0A, st & 8'hFE);
      chk("rx_byte", 8'hC3, serial_byte_register_o);
      go(0, 8'h00, 1, 0);
      chk("mack", {7'h00, aa[0]}, {7'h00, smb_remote_i.mack});
      chk("idle", 8'h00, st & 8'h08);
    end
    chk("stop_r", 8'h03, smb_remote_i.stops[7:0]);
    summarize();
  end
endmodule
`default_nettype wire
